// [verilog/sram_port_pkg.sv]
// constants, enumerations and widths shared by the burst sram port files
package sram_port_pkg;

    // ********************************************************
    // array geometry
    // ********************************************************
    // address pins, one word per address
    localparam int ADDR_W = 17;
    // number of words held by the array
    localparam int WORD_COUNT = 131072;
    // data pins and parity pins
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    // byte lanes, each eight data bits plus one parity bit
    localparam int BYTE_N = 4;
    localparam int BYTE_W = 8;
    // full stored word
    localparam int WORD_W = 36;

    // ********************************************************
    // burst counter
    // ********************************************************
    // beat counter width, four beats per loaded address
    localparam int BEAT_W = 2;
    // beat value right after a load
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    // counter step on each advance
    localparam logic [1:0] BEAT_STEP = 2'h1;

    // ********************************************************
    // byte enables and buffering
    // ********************************************************
    // byte write selects value that writes no byte
    localparam logic [3:0] BW_NONE = 4'hf;
    // depth of the write buffer in front of the array
    localparam int BUF_DEPTH = 32;

    // burst phase held between cycles, one-hot
    typedef enum logic [2:0]
    {
        PH_IDLE = 3'h1,
        PH_READ = 3'h2,
        PH_WRITE = 3'h4
    } phase_e;

endpackage

// [verilog/beat_stream_if.sv]
// valid/ready word stream between the port logic and its write buffer
`timescale 1ns/10ps
interface beat_stream_if #(
    parameter int W = 8
);
    // word offered by the source
    logic valid;
    // sink can take the word this cycle
    logic ready;
    // the word itself
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [verilog/stream_fifo.sv]
// first-word-fall-through fifo with valid and ready on both sides
`timescale 1ns/10ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    beat_stream_if.snk fill,
    beat_stream_if.src drain
);
    // depth must be a power of two so pointers wrap by themselves
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);

    // pointers and occupancy
    typedef struct packed
    {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } fifo_state_s;

    fifo_state_s state_reg;
    fifo_state_s state_next;
    // word storage
    logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
    logic push;
    logic pop;

    // honest flags: ready only with room, valid only with a word
    assign fill.ready = (state_reg.count != FULL_COUNT);
    assign drain.valid = (state_reg.count != '0);
    // head word shows without waiting for a pop
    assign drain.data = buf_mem[state_reg.rd_ptr];
    assign push = fill.valid & fill.ready;
    assign pop = drain.valid & drain.ready;

    // ********************************************************
    // pointer update
    // ********************************************************
    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        state_next.count = state_reg.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    // registers and storage write
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
        if (push)
        begin
            buf_mem[state_reg.wr_ptr] <= fill.data;
        end
    end

    // occupancy grows by one on a push without a pop
    a_count_tracks:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        (push && !pop) |=> state_reg.count == $past(state_reg.count) + 1'b1)
    else $error("fifo count did not grow on push");

endmodule // stream_fifo

// [verilog/burst_seq_gen.sv]
// low address bits of a burst beat, linear or interleaved order
`timescale 1ns/10ps
module burst_seq_gen
(
    input wire logic [1:0] start_low,
    input wire logic [1:0] beat,
    input wire logic interleave,
    output logic [1:0] addr_low
);
    // interleaved xors the beat in, linear adds it and wraps by four
    always_comb
    begin
        if (interleave)
        begin
            addr_low = start_low ^ beat;
        end
        else
        begin
            addr_low = start_low + beat;
        end
    end

endmodule // burst_seq_gen

// [verilog/pipelined_burst_sram_port.sv]
// synchronous burst sram: pipelined control, registered write data, flow-through read
`timescale 1ns/10ps

module pipelined_burst_sram_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int BUF_DEPTH = sram_port_pkg::BUF_DEPTH
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // active low clock qualifier
    input wire logic clock_qualify_n,
    // high advances burst, low loads a new address
    input wire logic advance_or_load,
    // high read, low write, sampled on load cycles
    input wire logic read_not_write,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b_n,
    input wire logic chip_select_hi,
    // active low byte write selects, bit n covers lane n
    input wire logic [3:0] byte_write_sel_n,
    // high interleaved, low linear
    input wire logic burst_order_sel,
    // asynchronous active low output enable
    input wire logic out_enable_n,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] data_bus_in,
    output logic [31:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [3:0] parity_bus_in,
    output logic [3:0] parity_bus_out,
    output logic parity_bus_oe,
    // holds the write buffer from draining into the array
    input wire logic write_hold,
    // write buffer has room for a captured write
    output logic buffer_ready
);

    // ********************************************************
    // types and storage
    // ********************************************************
    localparam int WORD_W = sram_port_pkg::WORD_W;
    localparam int BYTE_W = sram_port_pkg::BYTE_W;
    localparam int DATA_W = sram_port_pkg::DATA_W;
    // buffered write entry: address, byte selects, word
    localparam int ENTRY_W = ADDR_W + 4 + WORD_W;

    // clocked control state of the port; the write buffer and the array are held apart
    typedef struct packed
    {
        sram_port_pkg::phase_e phase;   // burst in progress and its direction
        logic [ADDR_W-1:0] base;        // address loaded at burst start
        logic [1:0] beat;               // burst beat counter
        logic dp_valid;                 // a data phase is due this cycle
        logic dp_write;                 // data phase direction
        logic [ADDR_W-1:0] dp_addr;     // address for the data phase
        logic [3:0] dp_bw_n;            // byte selects for the data phase
    } port_state_s;

    localparam port_state_s RESET_STATE = '{
        phase: sram_port_pkg::PH_IDLE,
        beat: sram_port_pkg::BEAT_FIRST,
        dp_bw_n: sram_port_pkg::BW_NONE,
        default: '0
    };

    port_state_s state_reg;
    port_state_s state_next;

    // word array, read without a register
    logic [WORD_W-1:0] sram_mem [0:(1<<ADDR_W)-1];

    // write buffer streams
    beat_stream_if #(.W(ENTRY_W)) wr_fill ();
    beat_stream_if #(.W(ENTRY_W)) wr_drain ();

    logic selected;         // all three chip selects true
    logic [1:0] next_beat;  // counter value after an advance
    logic [1:0] seq_low;    // low address bits for the next beat
    logic head_match;       // buffer head targets the read address
    logic [ADDR_W-1:0] head_addr;
    logic [3:0] head_bw_n;
    logic [WORD_W-1:0] head_word;
    logic [WORD_W-1:0] raw_word;    // array contents at the read address
    logic [WORD_W-1:0] rd_word;     // read word with pending write merged
    logic [WORD_W-1:0] old_word;    // array contents at the drain address
    logic [WORD_W-1:0] merged_word; // drain word merged under its selects
    logic drain_fire;

    // selection needs both lows low and the high one high
    assign selected = !chip_select_a_n && !chip_select_b_n && chip_select_hi;
    assign next_beat = state_reg.beat + sram_port_pkg::BEAT_STEP;

    // sequence generator picks order from the static select
    burst_seq_gen u_seq (
        .start_low(state_reg.base[1:0]),
        .beat(next_beat),
        .interleave(burst_order_sel),
        .addr_low(seq_low)
    );

    // ********************************************************
    // control pipeline
    // ********************************************************
    always_comb
    begin
        state_next = state_reg;
        // qualifier high leaves every register as it was
        if (!clock_qualify_n)
        begin
            if (!advance_or_load)
            begin
                if (selected)
                begin
                    state_next.base = addr_in;
                    state_next.beat = sram_port_pkg::BEAT_FIRST;
                    // new control taken with the address
                    state_next.dp_valid = 1'b1;
                    state_next.dp_addr = addr_in;
                    // direction comes from the load cycle
                    if (read_not_write)
                    begin
                        state_next.phase = sram_port_pkg::PH_READ;
                        state_next.dp_write = 1'b0;
                        state_next.dp_bw_n = sram_port_pkg::BW_NONE;
                    end
                    else
                    begin
                        state_next.phase = sram_port_pkg::PH_WRITE;
                        state_next.dp_write = 1'b1;
                        state_next.dp_bw_n = byte_write_sel_n;
                    end
                end
                else
                begin
                    // deselect stops the burst, no new access
                    state_next.phase = sram_port_pkg::PH_IDLE;
                    state_next.dp_valid = 1'b0;
                    state_next.dp_write = 1'b0;
                    state_next.dp_bw_n = sram_port_pkg::BW_NONE;
                end
            end
            else
            begin
                // advance uses the internal address only
                case (state_reg.phase)
                    sram_port_pkg::PH_READ:
                    begin
                        state_next.beat = next_beat;
                        state_next.dp_valid = 1'b1;
                        state_next.dp_write = 1'b0;
                        state_next.dp_addr = {state_reg.base[ADDR_W-1:2], seq_low};
                        state_next.dp_bw_n = sram_port_pkg::BW_NONE;
                    end
                    sram_port_pkg::PH_WRITE:
                    begin
                        // fresh byte selects on each write beat
                        state_next.beat = next_beat;
                        state_next.dp_valid = 1'b1;
                        state_next.dp_write = 1'b1;
                        state_next.dp_addr = {state_reg.base[ADDR_W-1:2], seq_low};
                        state_next.dp_bw_n = byte_write_sel_n;
                    end
                    default:
                    begin
                        state_next.dp_valid = 1'b0;
                        state_next.dp_write = 1'b0;
                        state_next.dp_bw_n = sram_port_pkg::BW_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= RESET_STATE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ********************************************************
    // write capture and buffer
    // ********************************************************
    // write data registered on the qualified edge of its data phase
    // a pending write is captured even if this cycle deselects
    assign wr_fill.valid = !clock_qualify_n && state_reg.dp_valid && state_reg.dp_write
        && (state_reg.dp_bw_n != sram_port_pkg::BW_NONE);
    assign wr_fill.data = {state_reg.dp_addr, state_reg.dp_bw_n, parity_bus_in, data_bus_in};
    assign buffer_ready = wr_fill.ready;
    // drain stops while suspended so the array looks frozen too
    assign wr_drain.ready = !clock_qualify_n && !write_hold;
    assign drain_fire = wr_drain.valid && wr_drain.ready;

    stream_fifo #(.WIDTH(ENTRY_W), .DEPTH(BUF_DEPTH)) u_wbuf (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fill(wr_fill),
        .drain(wr_drain)
    );

    assign head_addr = wr_drain.data[ENTRY_W-1 -: ADDR_W];
    assign head_bw_n = wr_drain.data[WORD_W +: 4];
    assign head_word = wr_drain.data[WORD_W-1:0];
    assign head_match = wr_drain.valid && (head_addr == state_reg.dp_addr);
    assign raw_word = sram_mem[state_reg.dp_addr];
    assign old_word = sram_mem[head_addr];

    // ********************************************************
    // byte lanes
    // ********************************************************
    // lane n is data bits 8n..8n+7 plus parity bit n
    for (genvar lane = 0; lane < sram_port_pkg::BYTE_N; lane++)
    begin : g_lane
        // selected lanes take the buffered data
        assign merged_word[lane*BYTE_W +: BYTE_W] = head_bw_n[lane]
            ? old_word[lane*BYTE_W +: BYTE_W] : head_word[lane*BYTE_W +: BYTE_W];
        assign merged_word[DATA_W+lane] = head_bw_n[lane]
            ? old_word[DATA_W+lane] : head_word[DATA_W+lane];
        // an unwritten head is forwarded so a read sees it
        assign rd_word[lane*BYTE_W +: BYTE_W] = (head_match && !head_bw_n[lane])
            ? head_word[lane*BYTE_W +: BYTE_W] : raw_word[lane*BYTE_W +: BYTE_W];
        assign rd_word[DATA_W+lane] = (head_match && !head_bw_n[lane])
            ? head_word[DATA_W+lane] : raw_word[DATA_W+lane];
    end

    // all selects low stores the full word
    always_ff @(posedge core_clk)
    begin
        if (drain_fire)
        begin
            sram_mem[head_addr] <= merged_word;
        end
    end

    // ********************************************************
    // read path
    // ********************************************************
    // flow-through, from the array with a matching buffer head merged in
    assign data_bus_out = rd_word[DATA_W-1:0];
    assign parity_bus_out = rd_word[WORD_W-1:DATA_W];
    // output enable gates the drive without the clock
    // write or deselect data phases never drive
    assign data_bus_oe = state_reg.dp_valid && !state_reg.dp_write && !out_enable_n;
    assign parity_bus_oe = data_bus_oe;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_suspend_holds:
    assert property (clock_qualify_n |=> state_reg == $past(state_reg))
    else $error("state changed on a suspended edge");

    a_load_addr:
    assert property ((!clock_qualify_n && !advance_or_load && selected)
        |=> state_reg.dp_addr == $past(addr_in) && state_reg.beat == 2'h0)
    else $error("load did not capture the address");

    a_load_dir:
    assert property ((!clock_qualify_n && !advance_or_load && selected)
        |=> state_reg.dp_valid && state_reg.dp_write == !$past(read_not_write))
    else $error("data phase direction wrong after load");

    a_read_bw_ignored:
    assert property ((!clock_qualify_n && !advance_or_load && selected && read_not_write)
        |=> state_reg.dp_bw_n == 4'hf)
    else $error("byte selects kept on a read");

    a_deselect_float:
    assert property ((!clock_qualify_n && !advance_or_load && !selected)
        |=> !data_bus_oe && !parity_bus_oe)
    else $error("bus driven after deselect");

    a_write_float:
    assert property ((!clock_qualify_n && !advance_or_load && selected && !read_not_write)
        |=> !data_bus_oe)
    else $error("bus driven in a write data phase");

    a_advance_dir:
    assert property ((!clock_qualify_n && advance_or_load
        && state_reg.phase != sram_port_pkg::PH_IDLE)
        |=> state_reg.dp_valid && state_reg.dp_write == $past(state_reg.dp_write)
        && state_reg.beat == $past(state_reg.beat) + 2'h1)
    else $error("advance changed direction or beat");

    a_noop_idle:
    assert property ((!clock_qualify_n && advance_or_load
        && state_reg.phase == sram_port_pkg::PH_IDLE) |=> !state_reg.dp_valid)
    else $error("advance from idle started an access");

    a_rw_turnaround:
    assert property ((!clock_qualify_n && !advance_or_load && selected && !read_not_write)
        ##1 (!clock_qualify_n && !advance_or_load && selected && read_not_write)
        |=> state_reg.dp_valid && !state_reg.dp_write && (data_bus_oe == !out_enable_n))
    else $error("read after write lost its data phase");

    a_oe_gate:
    assert property (out_enable_n |-> !data_bus_oe && !parity_bus_oe)
    else $error("bus driven with output enable high");

endmodule // pipelined_burst_sram_port

// [testbench/bus_master_model.sv]
// controller-side model driving the synchronous pins of the burst sram port
`timescale 1ns/10ps
module bus_master_model
(
    input wire logic core_clk,
    // {qualify_n, adv, rnw, sel_a_n, sel_b_n, sel_hi, byte_sel_n, order, oe_n, hold}
    output logic [12:0] ctl,
    output logic [16:0] addr,
    output logic [35:0] wdata
);
    // ********************************************************
    // pin driver
    // ********************************************************
    // idle deselected, byte selects off, linear order
    initial
    begin
        ctl = 13'h0ef8;
        addr = 17'h00000;
        wdata = 36'h000000000;
    end

    // one bus cycle, pins change just after the rising edge
    task automatic drive(input logic [12:0] c, input logic [16:0] a, input logic [35:0] d,
        input logic dv);
        @(posedge core_clk);
        // byte selects valid each cycle, order only moved when idle
        ctl <= c;
        addr <= a;
        // released lines show the inverse of the last value, never a stale copy
        wdata <= dv ? d : ~wdata;
    endtask
endmodule // bus_master_model

// [testbench/tb_pipelined_burst_sram_port.sv]
// self-checking bench for the burst sram port
`timescale 1ns/10ps
module tb_pipelined_burst_sram_port;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [12:0] ctl;
    logic [16:0] addr;
    logic [35:0] wdata;
    logic [31:0] data_bus_out;
    logic [3:0] parity_bus_out;
    logic data_bus_oe;
    logic parity_bus_oe;
    logic buffer_ready;
    int miscompares = 0;
    int checks = 0;
    // test-side settings folded into every control word
    logic ord = 1'b0;
    logic oen = 1'b0;
    logic hld = 1'b0;
    // expected array contents
    logic [35:0] mem [logic [16:0]];

    always #2 core_clk = ~core_clk;

    bus_master_model u_bus_master_model (.core_clk(core_clk), .ctl(ctl), .addr(addr),
        .wdata(wdata));

    pipelined_burst_sram_port u_pipelined_burst_sram_port (
        .core_clk(core_clk), .sys_rst(sys_rst), .clock_qualify_n(ctl[12]),
        .advance_or_load(ctl[11]), .read_not_write(ctl[10]), .chip_select_a_n(ctl[9]),
        .chip_select_b_n(ctl[8]), .chip_select_hi(ctl[7]), .byte_write_sel_n(ctl[6:3]),
        .burst_order_sel(ctl[2]), .out_enable_n(ctl[1]), .addr_in(addr),
        // wire level: the device wins while it drives, else the controller
        .data_bus_in(data_bus_oe ? data_bus_out : wdata[31:0]),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .parity_bus_in(parity_bus_oe ? parity_bus_out : wdata[35:32]),
        .parity_bus_out(parity_bus_out), .parity_bus_oe(parity_bus_oe),
        .write_hold(ctl[0]), .buffer_ready(buffer_ready));

    // ********************************************************
    // control words and helpers
    // ********************************************************
    function automatic logic [12:0] ld(input logic r, input logic [3:0] b);
        ld = {2'b00, r, 3'b001, b, ord, oen, hld};
    endfunction
    function automatic logic [12:0] av(input logic r);
        av = {2'b01, r, 3'b001, 4'h0, ord, oen, hld};
    endfunction
    function automatic logic [12:0] ds(input logic [2:0] s);
        ds = {3'b001, s, 4'hf, ord, oen, hld};
    endfunction
    function automatic logic [35:0] pat(input logic [16:0] x);
        pat = {x[3:0], ~x[15:0], x[15:0]};
    endfunction
    function automatic logic [35:0] ex(input logic [16:0] x);
        ex = mem.exists(x) ? mem[x] : 36'h000000000;
    endfunction
    // lane n is eight data bits plus parity bit n
    function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
        input logic [3:0] b);
        mrg = o;
        for (int i = 0; i < 4; i++)
            if (!b[i])
            begin
                mrg[8*i+:8] = n[8*i+:8];
                mrg[32+i] = n[32+i];
            end
    endfunction

    task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] s);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // one cycle: next controls, data and check for the phase now open
    // ck 0 no check, 1 read phase, 2 bus must float
    task automatic op(input logic [12:0] c, input logic [16:0] a, input logic [35:0] d,
        input logic dv, input logic [1:0] ck, input logic [35:0] e);
        u_bus_master_model.drive(c, a, d, dv);
        @(negedge core_clk);
        if (ck != 2'h0)
            cmp("oe", {34'h0, {2{ck == 2'h1 && !oen}}},
                {34'h0, data_bus_oe, parity_bus_oe});
        if (ck == 2'h1 && !oen)
            cmp("rdata", e, {parity_bus_out, data_bus_out});
    endtask

    // single access closed by a deselect, d is the write data
    task automatic acc(input logic r, input logic [16:0] a, input logic [3:0] b,
        input logic [35:0] d);
        op(ld(r, b), a, 36'h0, 1'b0, 2'h0, 36'h0);
        op(ds(3'b101), a, d, !r, r ? 2'h1 : 2'h2, ex(a));
        if (!r)
            mem[a] = mrg(ex(a), d, b);
    endtask

    // four beat burst in the current order
    task automatic brst(input logic r, input logic [16:0] a);
        logic [16:0] x;
        op(ld(r, 4'h0), a, 36'h0, 1'b0, 2'h0, 36'h0);
        for (int k = 0; k < 4; k++)
        begin
            x = {a[16:2], ord ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
            op(k < 3 ? av(!r) : ds(3'b101), a, pat(x), !r, r ? 2'h1 : 2'h2, ex(x));
            if (!r)
                mem[x] = pat(x);
        end
    endtask

    // ********************************************************
    // verdict
    // ********************************************************
    task automatic summarize;
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog well past the expected run length
    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        summarize;
    end

    // ********************************************************
    // test sequence
    // ********************************************************
    initial
    begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        // back-to-back write, read, write, read with no idle cycle
        op(ld(0, 4'h0), 17'h00010, 36'h0, 1'b0, 2'h0, 36'h0);
        op(ld(1, 4'h0), 17'h00010, pat(17'h00010), 1'b1, 2'h2, 36'h0);
        op(ld(0, 4'h0), 17'h00020, 36'h0, 1'b0, 2'h1, pat(17'h00010));
        op(ld(1, 4'h0), 17'h00020, pat(17'h00020), 1'b1, 2'h2, 36'h0);
        op(ds(3'b011), 17'h00020, 36'h0, 1'b0, 2'h1, pat(17'h00020));
        op(ds(3'b000), 17'h00020, 36'h0, 1'b0, 2'h2, 36'h0);
        mem[17'h00010] = pat(17'h00010);
        mem[17'h00020] = pat(17'h00020);
        acc(1, 17'h00010, 4'h0, 36'h0);
        // each byte lane alone, over a known full word since the array is not reset
        for (int n = 0; n < 4; n++)
        begin
            acc(0, 17'h00030 + n, 4'h0, ~pat(17'h00030 + n));
            acc(0, 17'h00030 + n, 4'hf, pat(17'h00030 + n));
            acc(0, 17'h00030 + n, ~(4'h1 << n), pat(17'h00030 + n));
            acc(1, 17'h00030 + n, 4'h0, 36'h0);
        end
        // bursts in linear then interleaved order, wrapping the low bits
        brst(0, 17'h00101);
        brst(1, 17'h00102);
        ord = 1'b1;
        brst(0, 17'h00205);
        brst(1, 17'h00103);
        brst(1, 17'h00206);
        ord = 1'b0;
        // deselect stops a burst, later advances do nothing
        op(ld(1, 4'h0), 17'h00101, 36'h0, 1'b0, 2'h0, 36'h0);
        op(av(0), 17'h00000, 36'h0, 1'b0, 2'h1, ex(17'h00101));
        op(ds(3'b000), 17'h00101, 36'h0, 1'b0, 2'h1, ex(17'h00102));
        op(av(0), 17'h00101, 36'h0, 1'b0, 2'h2, 36'h0);
        op(ds(3'b101), 17'h00101, 36'h0, 1'b0, 2'h2, 36'h0);
        // a qualified-off edge freezes the read phase
        op(ld(1, 4'h0), 17'h00020, 36'h0, 1'b0, 2'h0, 36'h0);
        op(ld(1, 4'h0) | 13'h1000, 17'h00010, 36'h0, 1'b0, 2'h1, ex(17'h00020));
        op(ds(3'b101), 17'h00010, 36'h0, 1'b0, 2'h1, ex(17'h00020));
        op(ds(3'b101), 17'h00010, 36'h0, 1'b0, 2'h2, 36'h0);
        // output enable high floats a read
        oen = 1'b1;
        acc(1, 17'h00020, 4'h0, 36'h0);
        oen = 1'b0;
        // write buffer: fill while held, then drain and read back
        hld = 1'b1;
        for (int i = 0; i < 32; i++)
            acc(0, 17'h00400 + i, 4'h0, pat(17'h00400 + i));
        op(ds(3'b101), 17'h00000, 36'h0, 1'b0, 2'h2, 36'h0);
        cmp("buffer_ready full", 36'h0, {35'h0, buffer_ready});
        hld = 1'b0;
        repeat (34) op(ds(3'b101), 17'h00000, 36'h0, 1'b0, 2'h2, 36'h0);
        cmp("buffer_ready empty", 36'h1, {35'h0, buffer_ready});
        for (int i = 0; i < 32; i++)
            acc(1, 17'h00400 + i, 4'h0, 36'h0);
        summarize;
    end
endmodule // tb_pipelined_burst_sram_port
